// >>> sdram_ctrl_pkg.sv
// Purpose: shared constants and carriers of the sdram controller configuration block
// Assumes: 32-bit peripheral bus, byte addresses as printed
// Notes:   field positions are the low bit of each field
package sdram_ctrl_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [31:0] ADDR_MEMORY_CONFIGURATION  = 32'hFFFFE808;
    localparam logic [31:0] ADDR_TIMING_PARAMETERS_ZERO = 32'hFFFFE80C;
    localparam logic [31:0] RESET_MEMORY_CONFIGURATION  = 32'h00007024;
    localparam logic [31:0] RESET_TIMING_PARAMETERS_ZERO = 32'h20227225;
    // reserved bits read as zero and ignore writes
    localparam logic [31:0] MASK_MEMORY_CONFIGURATION   = 32'h005573FF;
    localparam logic [31:0] MASK_TIMING_PARAMETERS_ZERO = 32'hFFFFFFFF;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int POS_COLUMN_BITS_SELECT = 0;
    localparam int POS_ROW_BITS_SELECT    = 2;
    localparam int POS_CAS_LATENCY        = 4;
    localparam int POS_DELAY_LOOP_RESET   = 7;
    localparam int POS_DRIVE_STRENGTH     = 8;
    localparam int POS_DELAY_LOOP_DISABLE = 9;
    localparam int POS_OFFCHIP_DRIVER     = 12;
    localparam int POS_SHARED_BUS         = 16;
    localparam int POS_BURST_STOP         = 18;
    localparam int POS_BANK_COUNT         = 20;
    localparam int POS_DECODING           = 22;
    localparam int POS_ACT_TO_PRE         = 0;

    // ************************************************************
    // decoded values
    // ************************************************************
    localparam logic [3:0] COL_BITS_SDR_BASE = 4'h8;
    localparam logic [3:0] COL_BITS_DDR_BASE = 4'h9;
    localparam logic [3:0] ROW_BITS_BASE     = 4'hB;
    localparam logic [2:0] CAS_CODE_TWO      = 3'h2;
    localparam logic [2:0] CAS_CODE_THREE    = 3'h3;
    localparam logic [1:0] BANK_BITS_FOUR    = 2'h2;
    localparam logic [1:0] BANK_BITS_EIGHT   = 2'h3;
    localparam int         BYTE_LANE_BITS    = 2;
    localparam int         MAX_BANKS         = 8;

    typedef enum logic {
        DECODE_SEQUENTIAL  = 1'b0,
        DECODE_INTERLEAVED = 1'b1
    } decoding_type_e;

    typedef struct packed {
        logic [3:0]     col_bits;
        logic [3:0]     row_bits;
        logic [1:0]     bank_bits;
        logic [2:0]     cas_cycles;
        logic           cas_reserved;
        logic           shared_external_bus;
        logic           burst_stop_restrict;
        decoding_type_e decoding_type;
        logic [3:0]     active_to_precharge_delay;
    } mem_cfg_s;

    // values sent to a ddr2 part while its mode registers are loaded at power-up
    typedef struct packed {
        logic       delay_loop_reset;
        logic       delay_loop_disable;
        logic       drive_strength_select;
        logic [2:0] offchip_driver_calibration;
    } mode_values_s;

endpackage

// >>> sdram_addr_split.sv
// Purpose: split a system byte address into bank, row and column
// Assumes: widths come from the configuration register, already decoded
// Notes:   outputs are registered, one cycle after the address
`timescale 1ns/100ps
module sdram_addr_split
    import sdram_ctrl_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           rst_b,
    input  wire logic [31:0]    sys_addr,
    input  wire logic [3:0]     col_bits,
    input  wire logic [3:0]     row_bits,
    input  wire logic [1:0]     bank_bits,
    input  wire decoding_type_e decoding_type,
    output logic [2:0]          bank_idx,
    output logic [13:0]         row_idx,
    output logic [11:0]         col_idx
);

    // ************************************************************
    // field extraction
    // ************************************************************
    wire logic [29:0] word      = sys_addr[31:BYTE_LANE_BITS];
    wire logic [29:0] col_mask  = ~(30'h3FFFFFFF << col_bits);
    wire logic [29:0] row_mask  = ~(30'h3FFFFFFF << row_bits);
    wire logic [29:0] bank_mask = ~(30'h3FFFFFFF << bank_bits);
    wire logic [29:0] above_col = word >> col_bits;
    // sequential puts bank above row; interleaved puts it just above column
    wire logic [29:0] row_part  = (decoding_type == DECODE_SEQUENTIAL) ?
                                  (above_col & row_mask) : ((above_col >> bank_bits) & row_mask);
    wire logic [29:0] bank_part = (decoding_type == DECODE_SEQUENTIAL) ?
                                  ((above_col >> row_bits) & bank_mask) : (above_col & bank_mask);
    wire logic [29:0] col_part  = word & col_mask;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_idx <= 3'h0;
            row_idx  <= 14'h0000;
            col_idx  <= 12'h000;
        end else begin
            bank_idx <= bank_part[2:0];
            row_idx  <= row_part[13:0];
            col_idx  <= col_part[11:0];
        end
    end

endmodule // sdram_addr_split

// >>> sdram_controller.sv
// Purpose: configuration and first timing register of the sdram controller
// Assumes: peripheral bus is apb on core_clk; mode and protect inputs are same-clock logic
// Notes:   only the active-to-precharge timing is enforced here
//
// Summary of operation
// - write protect set blocks both register writes
// - column code gives 9-12 ddr, 8-11 sdr
// - row code gives 11 to 14 row bits
// - latency 2 sdr only, 3 sdr/ddr2, else reserved
// - ddr2 dll reset and disable values, reset zero
// - ddr2 drive strength normal or weak at power-up
// - shared bus bit flags external bus sharing
// - burst stop restrict blocks cross-bank read stop, sdr only
// - eight banks only for ddr2, else four
// - decoding bit: sequential or interleaved
// - wait active-to-precharge count before precharge
`timescale 1ns/100ps
module sdram_controller
    import sdram_ctrl_pkg::*;
#(
    parameter int NUM_BANKS = MAX_BANKS
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic [31:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // system side
    input  wire logic        write_protect_enable,
    input  wire logic        sdr_mode,
    input  wire logic        ddr2_mode,
    input  wire logic [31:0] sys_addr,
    input  wire logic        activate_valid,
    input  wire logic [2:0]  activate_bank,
    input  wire logic        precharge_req,
    input  wire logic [2:0]  precharge_bank,
    output logic             precharge_grant,
    input  wire logic        read_start,
    input  wire logic [2:0]  read_bank,
    input  wire logic        burst_stop_req,
    output logic             burst_stop_grant,
    output mem_cfg_s         mem_cfg,
    output mode_values_s     mode_values,
    output logic [31:0]      timing_zero,
    output logic [2:0]       bank_idx,
    output logic [13:0]      row_idx,
    output logic [11:0]      col_idx
);

    // ************************************************************
    // register access
    // ************************************************************
    logic [31:0] memory_configuration;
    logic [31:0] timing_parameters_zero;

    wire logic hit_cfg   = (paddr == ADDR_MEMORY_CONFIGURATION);
    wire logic hit_tpr0  = (paddr == ADDR_TIMING_PARAMETERS_ZERO);
    wire logic access    = psel & penable;
    // a protected write is dropped silently; the bus sees no error
    wire logic wr_cfg    = access & pwrite & hit_cfg & ~write_protect_enable;
    wire logic wr_tpr0   = access & pwrite & hit_tpr0 & ~write_protect_enable;
    wire logic rd_setup  = psel & ~penable & ~pwrite;
    wire logic [31:0] rd_mux = hit_cfg ? memory_configuration :
                               hit_tpr0 ? timing_parameters_zero : 32'h00000000;

    assign pready  = 1'b1;
    assign pslverr = access & ~hit_cfg & ~hit_tpr0;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            memory_configuration <= RESET_MEMORY_CONFIGURATION;
        end else if (wr_cfg) begin
            memory_configuration <= pwdata & MASK_MEMORY_CONFIGURATION;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            timing_parameters_zero <= RESET_TIMING_PARAMETERS_ZERO;
        end else if (wr_tpr0) begin
            timing_parameters_zero <= pwdata & MASK_TIMING_PARAMETERS_ZERO;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    // ************************************************************
    // field decode
    // ************************************************************
    wire logic [1:0] col_code  = memory_configuration[POS_COLUMN_BITS_SELECT +: 2];
    wire logic [1:0] row_code  = memory_configuration[POS_ROW_BITS_SELECT +: 2];
    wire logic [2:0] cas_code  = memory_configuration[POS_CAS_LATENCY +: 3];
    wire logic       cas_ok    = ((cas_code == CAS_CODE_TWO) & sdr_mode) |
                                 ((cas_code == CAS_CODE_THREE) & (sdr_mode | ddr2_mode));
    // eight banks are honoured only on ddr2; other parts fall back to four
    wire logic       eight_ok  = memory_configuration[POS_BANK_COUNT] & ddr2_mode;

    assign mem_cfg.col_bits  = (sdr_mode ? COL_BITS_SDR_BASE : COL_BITS_DDR_BASE) + {2'h0, col_code};
    assign mem_cfg.row_bits  = ROW_BITS_BASE + {2'h0, row_code};
    assign mem_cfg.bank_bits = eight_ok ? BANK_BITS_EIGHT : BANK_BITS_FOUR;
    assign mem_cfg.cas_cycles   = cas_code;
    assign mem_cfg.cas_reserved = ~cas_ok;
    assign mem_cfg.shared_external_bus = memory_configuration[POS_SHARED_BUS];
    assign mem_cfg.burst_stop_restrict = memory_configuration[POS_BURST_STOP];
    assign mem_cfg.decoding_type = decoding_type_e'(memory_configuration[POS_DECODING]);
    assign mem_cfg.active_to_precharge_delay = timing_parameters_zero[POS_ACT_TO_PRE +: 4];

    assign mode_values.delay_loop_reset   = memory_configuration[POS_DELAY_LOOP_RESET];
    assign mode_values.delay_loop_disable = memory_configuration[POS_DELAY_LOOP_DISABLE];
    assign mode_values.drive_strength_select = memory_configuration[POS_DRIVE_STRENGTH];
    // no calibration is run here; the field is only handed on
    assign mode_values.offchip_driver_calibration = memory_configuration[POS_OFFCHIP_DRIVER +: 3];
    assign timing_zero = timing_parameters_zero;

    // ************************************************************
    // active to precharge timers
    // ************************************************************
    logic [NUM_BANKS-1:0] bank_ready;

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic [3:0] ras_count;
        wire logic  act_here = activate_valid & (activate_bank == 3'(b));
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                ras_count <= 4'h0;
            end else if (act_here) begin
                ras_count <= mem_cfg.active_to_precharge_delay;
            end else if (ras_count != 4'h0) begin
                ras_count <= ras_count - 4'h1;
            end
        end
        // an activate in this cycle also blocks, so a zero delay still costs one cycle
        assign bank_ready[b] = (ras_count == 4'h0) & ~act_here;

        property p_ras_hold;
            @(posedge core_clk) disable iff (!rst_b)
            act_here && mem_cfg.active_to_precharge_delay != 4'h0 |=> !bank_ready[b];
        endproperty
        a_ras_hold: assert property (p_ras_hold) else $error("precharge allowed too soon");

        property p_ras_release;
            @(posedge core_clk) disable iff (!rst_b)
            act_here ##1 !activate_valid [*8] |-> ##[0:8] bank_ready[b];
        endproperty
        a_ras_release: assert property (p_ras_release) else $error("bank never released");
    end

    assign precharge_grant = precharge_req & bank_ready[precharge_bank];

    // ************************************************************
    // burst stop gating
    // ************************************************************
    logic [2:0] open_read_bank;
    logic       foreign_activate;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            open_read_bank   <= 3'h0;
            foreign_activate <= 1'b0;
        end else if (read_start) begin
            open_read_bank   <= read_bank;
            foreign_activate <= 1'b0;
        end else if (activate_valid & (activate_bank != open_read_bank)) begin
            foreign_activate <= 1'b1;
        end
    end

    // only sdr-class parts honour the restriction
    assign burst_stop_grant = burst_stop_req &
                              ~(mem_cfg.burst_stop_restrict & sdr_mode & foreign_activate);

    // ************************************************************
    // address split
    // ************************************************************
    sdram_addr_split u_split (
        .core_clk      (core_clk),
        .rst_b         (rst_b),
        .sys_addr      (sys_addr),
        .col_bits      (mem_cfg.col_bits),
        .row_bits      (mem_cfg.row_bits),
        .bank_bits     (mem_cfg.bank_bits),
        .decoding_type (mem_cfg.decoding_type),
        .bank_idx      (bank_idx),
        .row_idx       (row_idx),
        .col_idx       (col_idx)
    );

    // ************************************************************
    // checks
    // ************************************************************
    property p_wp_cfg;
        @(posedge core_clk) disable iff (!rst_b)
        access && pwrite && hit_cfg && write_protect_enable |=> $stable(memory_configuration);
    endproperty
    a_wp_cfg: assert property (p_wp_cfg) else $error("protected config write landed");

    property p_wp_tpr0;
        @(posedge core_clk) disable iff (!rst_b)
        access && pwrite && hit_tpr0 && write_protect_enable |=> $stable(timing_parameters_zero);
    endproperty
    a_wp_tpr0: assert property (p_wp_tpr0) else $error("protected timing write landed");

    property p_cfg_write;
        @(posedge core_clk) disable iff (!rst_b)
        access && pwrite && hit_cfg && !write_protect_enable
        |=> memory_configuration == ($past(pwdata) & MASK_MEMORY_CONFIGURATION);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_col_bits;
        @(posedge core_clk) disable iff (!rst_b)
        sdr_mode |-> mem_cfg.col_bits == 4'(col_code) + 4'h8;
    endproperty
    a_col_bits: assert property (p_col_bits) else $error("sdr column width wrong");

    property p_row_bits;
        @(posedge core_clk) disable iff (!rst_b)
        (row_code == 2'h3) |-> mem_cfg.row_bits == 4'hE;
    endproperty
    a_row_bits: assert property (p_row_bits) else $error("row width wrong");

    property p_cas;
        @(posedge core_clk) disable iff (!rst_b)
        (cas_code == CAS_CODE_TWO) && ddr2_mode && !sdr_mode |-> mem_cfg.cas_reserved;
    endproperty
    a_cas: assert property (p_cas) else $error("latency two accepted for ddr2");

    property p_banks;
        @(posedge core_clk) disable iff (!rst_b)
        (mem_cfg.bank_bits == BANK_BITS_EIGHT) |-> ddr2_mode && memory_configuration[POS_BANK_COUNT];
    endproperty
    a_banks: assert property (p_banks) else $error("eight banks without ddr2");

    property p_burst_stop;
        @(posedge core_clk) disable iff (!rst_b)
        read_start ##[1:2] (activate_valid && activate_bank != open_read_bank && !read_start)
        ##1 (burst_stop_req && mem_cfg.burst_stop_restrict && sdr_mode && !read_start)
        |-> !burst_stop_grant;
    endproperty
    a_burst_stop: assert property (p_burst_stop) else $error("burst stop granted across banks");

endmodule // sdram_controller

// >>> sdram_mem_model.sv
// Purpose: memory-side watcher of activate to precharge spacing per bank
// Assumes: a precharge is issued when request and grant meet at an edge
// Notes:   counters saturate, so a bank never activated is always ready
`timescale 1ns/100ps
module sdram_mem_model (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       activate_valid,
    input  wire logic [2:0] activate_bank,
    input  wire logic       precharge_req,
    input  wire logic [2:0] precharge_bank,
    input  wire logic       precharge_grant,
    input  wire logic [3:0] act_to_pre,
    output logic [7:0]      viol_count
);
    // ************************************************************
    // cycles since the last activate of each bank
    // ************************************************************
    logic [3:0] since [8];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int b = 0; b < 8; b++) begin
                since[b] <= 4'hF;
            end
            viol_count <= 8'h00;
        end else begin
            for (int b = 0; b < 8; b++) begin
                if (since[b] != 4'hF) begin
                    since[b] <= since[b] + 4'h1;
                end
            end
            if (activate_valid) begin
                since[activate_bank] <= 4'h0;
            end
            // a row closed early loses its data in a real part
            if (precharge_req && precharge_grant && since[precharge_bank] < act_to_pre) begin
                viol_count <= viol_count + 8'h01;
            end
        end
    end
endmodule // sdram_mem_model

// >>> sdram_ctrl_config_timing_tb.sv
// Purpose: self-checking bench of the sdram controller configuration block
// Assumes: zero wait state apb, inputs driven 1 ns after the rising edge
// Notes:   expectations come from the register map, never from the design
`timescale 1ns/100ps
module sdram_ctrl_config_timing_tb;
    import sdram_ctrl_pkg::*;
    logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, sys_addr = 32'h0, prdata, timing_zero, q;
    logic write_protect_enable = 1'b0, sdr_mode = 1'b0, ddr2_mode = 1'b0, e;
    logic activate_valid = 1'b0, precharge_req = 1'b0, read_start = 1'b0, burst_stop_req = 1'b0;
    logic [2:0] activate_bank = 3'h0, precharge_bank = 3'h0, read_bank = 3'h0, bank_idx;
    logic pready, pslverr, precharge_grant, burst_stop_grant;
    logic [13:0] row_idx;
    logic [11:0] col_idx;
    logic [7:0] viol_count;
    mem_cfg_s mem_cfg;
    mode_values_s mode_values;
    int err_total = 0, total_checks = 0;

    always #5 core_clk = ~core_clk;

    sdram_controller dut (.core_clk(core_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .write_protect_enable(write_protect_enable), .sdr_mode(sdr_mode), .ddr2_mode(ddr2_mode),
        .sys_addr(sys_addr), .activate_valid(activate_valid), .activate_bank(activate_bank),
        .precharge_req(precharge_req), .precharge_bank(precharge_bank), .precharge_grant(precharge_grant),
        .read_start(read_start), .read_bank(read_bank), .burst_stop_req(burst_stop_req),
        .burst_stop_grant(burst_stop_grant), .mem_cfg(mem_cfg), .mode_values(mode_values),
        .timing_zero(timing_zero), .bank_idx(bank_idx), .row_idx(row_idx), .col_idx(col_idx));

    sdram_mem_model mem (.core_clk(core_clk), .rst_b(rst_b), .activate_valid(activate_valid),
        .activate_bank(activate_bank), .precharge_req(precharge_req), .precharge_bank(precharge_bank),
        .precharge_grant(precharge_grant), .act_to_pre(timing_zero[3:0]), .viol_count(viol_count));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic conclude();
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // pready is tied high, so the access phase always ends at the next edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        // idle edge first, so back-to-back calls never rewrite psel in one time step
        @(posedge core_clk) #1;
        psel = 1'b1;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(posedge core_clk) #1;
        penable = 1'b1;
        #4;
        q = prdata;
        e = pslverr;
        @(posedge core_clk) #1;
        psel = 1'b0;
        penable = 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
        chk(e, 32'h0);
        chk(pready, 32'h1);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        rd(ADDR_MEMORY_CONFIGURATION, RESET_MEMORY_CONFIGURATION);
        rd(ADDR_TIMING_PARAMETERS_ZERO, RESET_TIMING_PARAMETERS_ZERO);
        chk(mode_values, 6'b000111);
        apb(1'b0, 32'hFFFFE810, 32'h0);
        chk(e, 32'h1);
        chk(q, 32'h0);
    endtask

    task automatic t_protect();
        write_protect_enable = 1'b1;
        wr(ADDR_MEMORY_CONFIGURATION, 32'h0);
        wr(ADDR_TIMING_PARAMETERS_ZERO, 32'h0);
        rd(ADDR_MEMORY_CONFIGURATION, RESET_MEMORY_CONFIGURATION);
        rd(ADDR_TIMING_PARAMETERS_ZERO, RESET_TIMING_PARAMETERS_ZERO);
        write_protect_enable = 1'b0;
        wr(ADDR_MEMORY_CONFIGURATION, 32'hFFFFFFFF);
        rd(ADDR_MEMORY_CONFIGURATION, MASK_MEMORY_CONFIGURATION);
    endtask

    task automatic t_geom();
        for (int s = 0; s < 2; s++) begin
            sdr_mode = s[0];
            for (int c = 0; c < 4; c++) begin
                // bench data bus is 32-bit, so sdr with eight columns stays legal
                wr(ADDR_MEMORY_CONFIGURATION, (c << 2) | c | 32'h20);
                chk(mem_cfg.col_bits, (s ? 8 : 9) + c);
                chk(mem_cfg.row_bits, 11 + c);
            end
        end
    endtask

    task automatic t_cas();
        for (int m = 0; m < 3; m++) begin
            sdr_mode = (m == 1);
            ddr2_mode = (m == 2);
            for (int c = 0; c < 8; c++) begin
                wr(ADDR_MEMORY_CONFIGURATION, c << 4);
                chk(mem_cfg.cas_cycles, c);
                chk(mem_cfg.cas_reserved, !((c == 2 && m == 1) || (c == 3 && m != 0)));
            end
        end
    endtask

    // two opposite patterns catch swapped or stuck field bits
    task automatic t_flags();
        ddr2_mode = 1'b1;
        sdr_mode = 1'b0;
        wr(ADDR_MEMORY_CONFIGURATION, 32'h00517080);
        chk(mode_values, 6'b100111);
        chk({mem_cfg.shared_external_bus, mem_cfg.burst_stop_restrict, mem_cfg.decoding_type}, 3'b101);
        chk(mem_cfg.bank_bits, BANK_BITS_EIGHT);
        ddr2_mode = 1'b0;
        #4;
        chk(mem_cfg.bank_bits, BANK_BITS_FOUR);
        wr(ADDR_MEMORY_CONFIGURATION, 32'h00040300);
        chk(mode_values, 6'b011000);
        chk({mem_cfg.shared_external_bus, mem_cfg.burst_stop_restrict, mem_cfg.decoding_type}, 3'b010);
        chk(mem_cfg.bank_bits, BANK_BITS_FOUR);
    endtask

    task automatic t_delay(input logic [3:0] n);
        wr(ADDR_TIMING_PARAMETERS_ZERO, {RESET_TIMING_PARAMETERS_ZERO[31:4], n});
        chk(timing_zero, {RESET_TIMING_PARAMETERS_ZERO[31:4], n});
        activate_bank = 3'h2;
        precharge_bank = 3'h2;
        activate_valid = 1'b1;
        precharge_req = 1'b1;
        for (int i = 0; i <= n + 1; i++) begin
            #4;
            chk(precharge_grant, i > n);
            @(posedge core_clk) #1;
            activate_valid = 1'b0;
        end
        precharge_req = 1'b0;
    endtask

    task automatic t_burst(input logic r);
        wr(ADDR_MEMORY_CONFIGURATION, RESET_MEMORY_CONFIGURATION | (r << 18));
        sdr_mode = 1'b1;
        read_bank = 3'h0;
        read_start = 1'b1;
        @(posedge core_clk) #1;
        read_start = 1'b0;
        burst_stop_req = 1'b1;
        #4;
        chk(burst_stop_grant, 32'h1);
        @(posedge core_clk) #1;
        burst_stop_req = 1'b0;
        activate_bank = 3'h1;
        activate_valid = 1'b1;
        @(posedge core_clk) #1;
        activate_valid = 1'b0;
        burst_stop_req = 1'b1;
        #4;
        chk(burst_stop_grant, !r);
        @(posedge core_clk) #1;
        burst_stop_req = 1'b0;
        sdr_mode = 1'b0;
    endtask

    task automatic t_split(input logic il);
        wr(ADDR_MEMORY_CONFIGURATION, RESET_MEMORY_CONFIGURATION | (il << 22));
        sys_addr = 32'h01ABCDEF;
        @(posedge core_clk) #1;
        chk(col_idx, sys_addr[10:2]);
        chk(row_idx, il ? sys_addr[24:13] : sys_addr[22:11]);
        chk(bank_idx, il ? sys_addr[12:11] : sys_addr[24:23]);
    endtask

    initial begin
        #100000;
        err_total++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_protect();
        t_geom();
        t_cas();
        t_flags();
        t_delay(4'h0);
        t_delay(4'h3);
        t_delay(4'hF);
        t_burst(1'b1);
        t_burst(1'b0);
        t_split(1'b0);
        t_split(1'b1);
        chk(viol_count, 32'h0);
        conclude();
    end
endmodule // sdram_ctrl_config_timing_tb
